/* rtl/wwst_consts.vh */
// Purpose: shared constants of the window watchdog
// Assumes: included by bare name
// Notes:   definitions only
`ifndef WWST_CONSTS_VH
`define WWST_CONSTS_VH
// ****************************************
// register map (byte addresses, low bits)
// ****************************************
`define WWST_AW           8
`define WWST_ADDR_ENABLE  8'h00
`define WWST_ADDR_VAC     8'h04
`define WWST_ADDR_REF     8'h08
`define WWST_ADDR_MODE    8'h0c
`define WWST_ADDR_STAT    8'h10
// ****************************************
// mode register fields and reset values
// ****************************************
`define WWST_MD_W         7
`define WWST_MD_OVF_MSB   2
`define WWST_MD_OVF_LSB   0
`define WWST_MD_WIE       3
`define WWST_MD_ERM       4
`define WWST_MD_WS_MSB    6
`define WWST_MD_WS_LSB    5
`define WWST_MD_WS_INIT   2'h3
`define WWST_MD_WIE_INIT  1'b0
`define WWST_MD_ERM_INIT  1'b1
// ****************************************
// codes, counter marks, timing
// ****************************************
`define WWST_ACT_CODE     8'hac
`define WWST_CODE_INIT    8'h2c
`define WWST_EN_LOW_INIT  7'h2c
`define WWST_REF_INIT     8'h00
`define WWST_CNT_ZERO     16'h0000
`define WWST_CNT_ONE      16'h0001
`define WWST_CNT_MAX      16'hffff
`define WWST_CNT_WARN     16'hc000
`define WWST_WIN_25       16'hc000
`define WWST_WIN_50       16'h8000
`define WWST_WIN_75       16'h4000
`define WWST_WIN_100      16'h0000
`define WWST_DIV_BASE     5'h09
`define WWST_SYNC_WAIT    2'h3
`define WWST_RESP_OKAY    2'h0
`define WWST_RESP_SLVERR  2'h2
`endif

/* rtl/wwst_prescale.v */
// Purpose: count clock divider, one-cycle tick
// Assumes: tck_i already synchronised
// Notes:   divides tck edges by 2^(9+sel)
`include "wwst_consts.vh"
`timescale 1ns/10ps
module wwst_prescale (
  input  wire       clk_i,
  input  wire       rstn_i,
  input  wire       tck_i,
  input  wire       clr_i,
  input  wire [2:0] sel_i,
  output reg        tick_o
);
  reg  [15:0] div_reg;
  reg         tck_d_reg;
  wire        edge_w;
  wire [4:0]  shift_w;
  wire [15:0] mask_w;

  assign edge_w  = tck_i & ~tck_d_reg;
  assign shift_w = `WWST_DIV_BASE + {2'h0, sel_i};
  assign mask_w  = (`WWST_CNT_ONE << shift_w) - `WWST_CNT_ONE;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg   <= `WWST_CNT_ZERO;
      tck_d_reg <= 1'b0;
      tick_o    <= 1'b0;
    end else begin
      tck_d_reg <= tck_i;
      tick_o    <= 1'b0;
      if (clr_i) begin
        div_reg <= `WWST_CNT_ZERO;
      end else if (edge_w) begin
        div_reg <= div_reg + `WWST_CNT_ONE;
        tick_o  <= ((div_reg & mask_w) == mask_w); // [RULE14]
      end
    end
  end
endmodule // wwst_prescale

/* rtl/wwst_sync.v */
// Purpose: two-stage synchroniser for pins
// Assumes: async inputs, one clock
// Notes:   first stage read only by second
`timescale 1ns/10ps
module wwst_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rstn_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_reg;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= {W{1'b0}};
      q_o      <= {W{1'b0}};
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule // wwst_sync

/* rtl/wwst_top.v */
// Purpose: window watchdog with start-up options and trigger codes
// Assumes: AXI4-Lite slave, 100 MHz clk_i, straps stable at reset
// Notes:   errors stop the watchdog until the next reset
//
// Summary of operation
// [RULE1] enabled: auto-run option zero means software start
// [RULE2] enable option zero disables watchdog for good
// [RULE3] 16-bit counter; errors raise nmi or reset
// [RULE4] valid trigger in window clears counter
// [RULE5] warning pulse at three quarters of range
// [RULE6] software start: counter zero until first trigger
// [RULE7] automatic start counts at release; trigger before overflow
// [RULE8] selector picks auto-run or reset-type input; with selector set the code starts only on auto-run AND reset-type
// [RULE9] before first trigger errors give reset
// [RULE10] before first trigger window is full range
// [RULE11] before first trigger clock and warning from options; the code keeps the warning off until then (WWST_MD_WIE_INIT)
// [RULE12] mode writes held, applied at first trigger
// [RULE13] mode change after first trigger is error
// [RULE14] count clock divided by two to 9+code
// [RULE15] option picks fixed or variable code trigger
// [RULE16] expected code is ac minus reference
// [RULE17] each variable write loads rotated expected code
// [RULE18] reference updates on bad trigger too
// [RULE19] reference resets to zero
// [RULE20] variable register bit 7 stays set when running
// [RULE21] wrong code or closed window is error
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`include "wwst_consts.vh"
`timescale 1ns/10ps
module wwst_top (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire        wd_enable_option_i,
  input  wire        auto_run_option_i,
  input  wire        start_source_selector_i,
  input  wire        reset_type_input_i,
  input  wire [2:0]  initial_count_clock_option_i,
  input  wire        variable_code_option_i,
  input  wire        count_clock_input_i,
  input  wire [31:0] s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output reg         s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output reg         s_axi_wready_o,
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [31:0] s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output reg         s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  output reg         warning_interrupt_o,
  output reg         error_nmi_request_o,
  output reg         error_reset_output_o
);
  localparam [3:0] ST_CAPT = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_RUN  = 4'h4;
  localparam [3:0] ST_STOP = 4'h8;

  // ****************************************
  // functions
  // ****************************************
  function [4:0] addr_dec;
    input [31:0] a;
    begin
      addr_dec = 5'h00;
      if (a[31:`WWST_AW] == 24'h000000) begin
        case (a[`WWST_AW-1:0])
          `WWST_ADDR_ENABLE: addr_dec = 5'h01;
          `WWST_ADDR_VAC:    addr_dec = 5'h02;
          `WWST_ADDR_REF:    addr_dec = 5'h04;
          `WWST_ADDR_MODE:   addr_dec = 5'h08;
          `WWST_ADDR_STAT:   addr_dec = 5'h10;
          default:           addr_dec = 5'h00;
        endcase
      end
    end
  endfunction

  function [15:0] win_start;
    input [1:0] ws;
    begin
      case (ws)
        2'h0:    win_start = `WWST_WIN_25;
        2'h1:    win_start = `WWST_WIN_50;
        2'h2:    win_start = `WWST_WIN_75;
        default: win_start = `WWST_WIN_100;
      endcase
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  wire [7:0] opt_sync;
  wire       tck_sync;
  wire       tick;
  reg  [3:0] state_reg;
  reg  [1:0] wait_reg;
  reg        opt_vac_reg;
  reg  [2:0] opt_ovf_reg;
  reg        first_reg;
  reg        run_reg;
  reg        err_reg;
  reg  [`WWST_MD_W-1:0] md_pend_reg;
  reg  [`WWST_MD_W-1:0] md_act_reg;
  reg  [7:0]  ref_reg;
  reg  [7:0]  evac_reg;
  reg  [15:0] cnt_reg;
  reg         aw_held_reg;
  reg         w_held_reg;
  reg  [31:0] awaddr_reg;
  reg  [7:0]  wdata_reg;
  reg         wstrb0_reg;
  reg         aw_held_next;
  reg         w_held_next;
  reg         rvalid_next;
  reg  [31:0] rdata_next;
  wire        aw_take;
  wire        w_take;
  wire        ar_take;
  wire        wr_go;
  wire [4:0]  wdec;
  wire [4:0]  rdec;
  wire        w_en;
  wire        w_vac;
  wire        w_md;
  wire        active;
  wire        auto_start;
  wire [7:0]  exp_code;
  wire        trig_wr;
  wire        code_ok;
  wire        win_ok;
  wire        trig_good;
  wire        trig_bad;
  wire        md_bad;
  wire        ovf;
  wire        err_now;
  wire        erm_eff;
  wire        wie_eff;
  wire [2:0]  ovf_eff;
  wire [15:0] cnt_inc;

  // ****************************************
  // pin synchronisers and count clock
  // ****************************************
  wwst_sync #(.W(8)) u_opt_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({variable_code_option_i, initial_count_clock_option_i, reset_type_input_i,
              start_source_selector_i, auto_run_option_i, wd_enable_option_i}),
    .q_o    (opt_sync)
  );

  wwst_sync #(.W(1)) u_tck_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (count_clock_input_i),
    .q_o    (tck_sync)
  );

  wwst_prescale u_prescale (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tck_i  (tck_sync),
    .clr_i  (trig_good),
    .sel_i  (ovf_eff),
    .tick_o (tick)
  );

  // ****************************************
  // trigger and error decisions
  // ****************************************
  assign wr_go      = aw_held_reg & w_held_reg & ~s_axi_bvalid_o;
  assign wdec       = addr_dec(awaddr_reg);
  assign rdec       = addr_dec(s_axi_araddr_i);
  assign w_en       = wr_go & wstrb0_reg & wdec[0];
  assign w_vac      = wr_go & wstrb0_reg & wdec[1];
  assign w_md       = wr_go & wstrb0_reg & wdec[3];
  assign active     = state_reg[1] | state_reg[2];
  assign auto_start = opt_sync[2] ? (opt_sync[1] & opt_sync[3]) : opt_sync[1]; // [RULE8] [RULE1]
  assign exp_code   = `WWST_ACT_CODE - ref_reg; // [RULE16]
  assign trig_wr    = opt_vac_reg ? w_vac : w_en; // [RULE15]
  assign code_ok    = (wdata_reg == (opt_vac_reg ? exp_code : `WWST_ACT_CODE));
  assign win_ok     = ~first_reg |
                      (cnt_reg >= win_start(md_act_reg[`WWST_MD_WS_MSB:`WWST_MD_WS_LSB])); // [RULE10]
  assign trig_good  = active & trig_wr & code_ok & win_ok;
  assign trig_bad   = active & trig_wr & ~(code_ok & win_ok); // [RULE21] [RULE18]
  assign md_bad     = active & first_reg & w_md &
                      (wdata_reg[`WWST_MD_W-1:0] != md_act_reg); // [RULE13]
  assign ovf        = state_reg[2] & tick & (cnt_reg == `WWST_CNT_MAX); // [RULE3]
  assign err_now    = trig_bad | md_bad | ovf;
  assign erm_eff    = first_reg ? md_act_reg[`WWST_MD_ERM] : 1'b1; // [RULE9]
  assign wie_eff    = first_reg ? md_act_reg[`WWST_MD_WIE] : `WWST_MD_WIE_INIT; // [RULE11]
  assign ovf_eff    = first_reg ? md_act_reg[`WWST_MD_OVF_MSB:`WWST_MD_OVF_LSB] : opt_ovf_reg; // [RULE11]
  assign cnt_inc    = cnt_reg + `WWST_CNT_ONE;

  // ****************************************
  // watchdog core
  // ****************************************
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg            <= ST_CAPT;
      wait_reg             <= 2'h0;
      opt_vac_reg          <= 1'b0;
      opt_ovf_reg          <= 3'h0;
      first_reg            <= 1'b0;
      run_reg              <= 1'b0;
      err_reg              <= 1'b0;
      md_pend_reg          <= {`WWST_MD_W{1'b0}};
      md_act_reg           <= {`WWST_MD_W{1'b0}};
      ref_reg              <= `WWST_REF_INIT; // [RULE19]
      evac_reg             <= `WWST_CODE_INIT;
      cnt_reg              <= `WWST_CNT_ZERO;
      warning_interrupt_o  <= 1'b0;
      error_nmi_request_o  <= 1'b0;
      error_reset_output_o <= 1'b0;
    end else begin
      warning_interrupt_o <= 1'b0;
      if (opt_vac_reg && w_vac) begin
        ref_reg  <= {exp_code[6:0], exp_code[7]}; // [RULE17] [RULE18]
        evac_reg <= wdata_reg;
      end
      if (w_md && !first_reg) begin
        md_pend_reg <= wdata_reg[`WWST_MD_W-1:0]; // [RULE12]
      end
      case (state_reg)
        ST_CAPT: begin
          if (wait_reg != `WWST_SYNC_WAIT) begin
            wait_reg <= wait_reg + 2'h1;
          end else begin
            opt_vac_reg <= opt_sync[7];
            opt_ovf_reg <= opt_sync[6:4];
            md_pend_reg <= {`WWST_MD_WS_INIT, `WWST_MD_ERM_INIT, `WWST_MD_WIE_INIT, opt_sync[6:4]};
            if (!opt_sync[0]) begin
              state_reg <= ST_STOP; // [RULE2]
            end else if (auto_start) begin
              state_reg <= ST_RUN; // [RULE7]
              run_reg   <= 1'b1;
            end else begin
              state_reg <= ST_IDLE; // [RULE6]
            end
          end
        end
        ST_IDLE, ST_RUN: begin
          if (err_now) begin
            state_reg            <= ST_STOP;
            err_reg              <= 1'b1;
            error_reset_output_o <= erm_eff; // [RULE3] [RULE9]
            error_nmi_request_o  <= ~erm_eff;
          end else if (trig_good) begin
            state_reg <= ST_RUN;
            cnt_reg   <= `WWST_CNT_ZERO; // [RULE4]
            run_reg   <= 1'b1;
            if (!first_reg) begin
              first_reg  <= 1'b1;
              md_act_reg <= md_pend_reg; // [RULE12]
            end
          end else if (state_reg[2] && tick) begin
            cnt_reg <= cnt_inc;
            warning_interrupt_o <= wie_eff & (cnt_inc == `WWST_CNT_WARN); // [RULE5]
          end
        end
        ST_STOP: begin
          state_reg <= ST_STOP;
        end
        default: begin
          state_reg <= ST_STOP;
        end
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite write channels
  // ****************************************
  assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
  assign w_take  = s_axi_wvalid_i & s_axi_wready_o;

  always @* begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    if (wr_go) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
    end
    if (aw_take) begin
      aw_held_next = 1'b1;
    end
    if (w_take) begin
      w_held_next = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      awaddr_reg      <= 32'h00000000;
      wdata_reg       <= 8'h00;
      wstrb0_reg      <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `WWST_RESP_OKAY;
    end else begin
      aw_held_reg     <= aw_held_next;
      w_held_reg      <= w_held_next;
      s_axi_awready_o <= ~aw_held_next;
      s_axi_wready_o  <= ~w_held_next;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr_i;
      end
      if (w_take) begin
        wdata_reg  <= s_axi_wdata_i[7:0];
        wstrb0_reg <= s_axi_wstrb_i[0];
      end
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (wdec == 5'h00) ? `WWST_RESP_SLVERR : `WWST_RESP_OKAY;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channels
  // ****************************************
  assign ar_take = s_axi_arvalid_i & s_axi_arready_o;

  always @* begin
    rvalid_next = s_axi_rvalid_o;
    if (s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (ar_take) begin
      rvalid_next = 1'b1;
    end
    rdata_next = 32'h00000000;
    case (rdec)
      5'h01:   rdata_next = {24'h000000, run_reg, `WWST_EN_LOW_INIT};
      5'h02:   rdata_next = {24'h000000, evac_reg[7] | run_reg, evac_reg[6:0]}; // [RULE20]
      5'h04:   rdata_next = {24'h000000, ref_reg};
      5'h08:   rdata_next = {25'h0000000, md_pend_reg};
      5'h10:   rdata_next = {13'h0000, err_reg, run_reg, first_reg, cnt_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h00000000;
      s_axi_rresp_o   <= `WWST_RESP_OKAY;
    end else begin
      s_axi_rvalid_o  <= rvalid_next;
      s_axi_arready_o <= ~rvalid_next;
      if (ar_take) begin
        s_axi_rdata_o <= rdata_next;
        s_axi_rresp_o <= (rdec == 5'h00) ? `WWST_RESP_SLVERR : `WWST_RESP_OKAY;
      end
    end
  end
endmodule // wwst_top

/* testbench/wwst_chk_asserts.sv */
// Purpose: port checks on the watchdog top
// Assumes: bound into wwst_top, one clock
// Notes:   error outputs are held levels
`timescale 1ns/10ps
module wwst_chk (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        wd_enable_option_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        warning_interrupt_o,
  input wire logic        error_nmi_request_o,
  input wire logic        error_reset_output_o
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_NMI_HOLD: assert property (error_nmi_request_o |=> error_nmi_request_o)
    else $error("nmi request dropped before reset");
  AST_RES_HOLD: assert property (error_reset_output_o |=> error_reset_output_o)
    else $error("reset output dropped before reset");
  AST_ONE_ERR: assert property (!(error_nmi_request_o && error_reset_output_o))
    else $error("both error outputs high");
  AST_DIS_QUIET: assert property (!wd_enable_option_i |-> !error_nmi_request_o && !error_reset_output_o)
    else $error("disabled watchdog raised an error");
  AST_WARN_PULSE: assert property (warning_interrupt_o |=> !warning_interrupt_o)
    else $error("warning longer than one cycle");
  AST_B_TIME: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  AST_R_TIME: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data late");
  AST_B_STAND: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response not held");
  AST_R_STAND: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
  AST_UNMAPPED: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:0] == 8'h14
    |=> s_axi_rresp_o == 2'h2)
    else $error("unmapped read not refused");
  cover property ($rose(error_nmi_request_o));
  cover property ($rose(error_reset_output_o));
  cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule // wwst_chk
bind wwst_top wwst_chk u_wwst_chk (.*);

/* testbench/wwst_tb.sv */
// Purpose: self-checking bench for the watchdog top
// Assumes: axi4-lite master tasks, straps set in reset
// Notes:   count clock made by bench, 6 clk period
`timescale 1ns/10ps
module tb_top;
  // ****************************************
  // signals, clock, tasks
  // ****************************************
  logic        clk_i, rstn_i, wd_enable_option_i, auto_run_option_i, start_source_selector_i;
  logic        reset_type_input_i, variable_code_option_i, count_clock_input_i;
  logic [2:0]  initial_count_clock_option_i;
  logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i;
  logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic        s_axi_rvalid_o, s_axi_rready_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic        warning_interrupt_o, error_nmi_request_o, error_reset_output_o;
  int          fail_count, n_compared;
  wwst_top u_wwst_top (.*);
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ck_err(input logic [1:0] e);
    chk({30'h0, error_nmi_request_o, error_reset_output_o}, {30'h0, e});
  endtask
  task automatic tck(input int n);
    repeat (n) begin
      count_clock_input_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      count_clock_input_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  // straps {enable, auto run, selector, reset type, variable code}
  task automatic rst(input logic [4:0] o);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    {wd_enable_option_i, auto_run_option_i, start_source_selector_i, reset_type_input_i,
     variable_code_option_i} <= o;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr_i <= {24'h0, a};
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    fork
      begin do @(posedge clk_i); while (!s_axi_awready_o); s_axi_awvalid_i <= 1'b0; end
      begin do @(posedge clk_i); while (!s_axi_wready_o); s_axi_wvalid_i <= 1'b0; end
    join
    repeat (2) @(posedge clk_i);
    s_axi_bready_i <= 1'b1;
    do @(posedge clk_i); while (!s_axi_bvalid_o);
    chk({30'h0, s_axi_bresp_o}, (a == 8'h14) ? 32'h2 : 32'h0);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    s_axi_araddr_i <= {24'h0, a};
    s_axi_arvalid_i <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    s_axi_rready_i <= 1'b1;
    do @(posedge clk_i); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
    chk(s_axi_rdata_o, exp);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_sel;
    logic [3:0] c [6] = '{4'b0000, 4'b1001, 4'b0100, 4'b1100, 4'b1111, 4'b0110};
    for (int i = 0; i < 6; i++) begin
      rst({1'b1, c[i][3:1], 1'b0});
      rd(8'h00, {24'h0, c[i][0], 7'h2c});
    end
  endtask
  task automatic t_dis;
    rst(5'b01000);
    wr(8'h00, 8'hac);
    rd(8'h00, 32'h2c);
    rd(8'h10, 32'h0);
    ck_err(2'b00);
  endtask
  task automatic t_sw;
    rst(5'b10000);
    tck(600);
    wr(8'h14, 8'hac);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    wr(8'h00, 8'hac);
    rd(8'h00, 32'hac);
    tck(600);
    rd(8'h10, 32'h30001);
    wr(8'h00, 8'hac);
    rd(8'h10, 32'h30000);
  endtask
  task automatic t_auto;
    initial_count_clock_option_i <= 3'h1;
    rst(5'b11000);
    tck(600);
    rd(8'h10, 32'h20000);
    tck(500);
    rd(8'h10, 32'h20001);
  endtask
  task automatic t_vac;
    rst(5'b10001);
    rd(8'h08, 32'h0);
    wr(8'h04, 8'hac);
    rd(8'h08, 32'h59);
    wr(8'h04, 8'h53);
    rd(8'h08, 32'ha6);
    wr(8'h04, 8'h06);
    rd(8'h04, 32'h86);
    rd(8'h08, 32'h0c);
    ck_err(2'b00);
    wr(8'h04, 8'h11);
    rd(8'h08, 32'h41);
    ck_err(2'b01);
  endtask
  task automatic t_win;
    rst(5'b11000);
    wr(8'h0c, 8'h08);
    wr(8'h00, 8'hac);
    ck_err(2'b00);
    wr(8'h00, 8'hac);
    ck_err(2'b10);
  endtask
  task automatic t_early;
    rst(5'b11000);
    wr(8'h0c, 8'h08);
    wr(8'h00, 8'h55);
    ck_err(2'b01);
  endtask
  task automatic t_chg;
    rst(5'b11000);
    wr(8'h0c, 8'h68);
    wr(8'h00, 8'hac);
    wr(8'h0c, 8'h68);
    ck_err(2'b00);
    wr(8'h0c, 8'h69);
    ck_err(2'b10);
  endtask
  initial begin
    {rstn_i, wd_enable_option_i, auto_run_option_i, start_source_selector_i} = 4'h0;
    {reset_type_input_i, variable_code_option_i, count_clock_input_i} = 3'h0;
    initial_count_clock_option_i = 3'h0;
    {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i} = '0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h0;
    s_axi_wstrb_i = 4'hf;
    fail_count = 0;
    n_compared = 0;
    t_sel;
    t_dis;
    t_sw;
    t_auto;
    t_vac;
    t_win;
    t_early;
    t_chg;
    wrap_up;
  end
  initial begin
    #500_000;
    fail_count++;
    wrap_up;
  end
endmodule // tb_top
